// ---- hdl/dwell_filter.sv ----
// dwell filter: active rises only after raw held high LEN cycles
// assumes raw is already synchronised to sys_clk
`timescale 1ns/1ps
module dwell_filter
    import reset_seq_pkg::*;
#(
    parameter int unsigned LEN = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    filter_if.filt   port
);
    logic [15:0] cnt_q;
    logic        act_q;

    // release is immediate; only the assert side is filtered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            act_q <= 1'b0;
        end else if (!port.raw) begin
            cnt_q <= 16'h0000;
            act_q <= 1'b0;
        end else if (cnt_q >= 16'(LEN - 1)) begin
            act_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign port.active = act_q;
endmodule : dwell_filter

// ---- hdl/reset_timeout_sequencer.sv ----
// reset generation and power-up time-out sequencing
// assumes analog detectors, rc clock and oscillator pin arrive asynchronous
`timescale 1ns/1ps
module reset_timeout_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = DELAY_COUNT
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       por_pulse,
    input  wire logic       brownout_detect,
    input  wire logic       master_clear_pin,
    input  wire logic       watchdog_timeout,
    input  wire logic       sleep_active,
    input  wire logic       internal_rc_clock,
    input  wire logic       oscillator_input_pin,
    input  wire logic [1:0] osc_mode,
    input  wire logic       brownout_enable_bit,
    input  wire logic [1:0] brownout_trip_select,
    input  wire logic       power_up_delay_enable_bit,
    input  wire logic       retained_written,
    input  wire logic       por_flag_set,
    output logic            core_reset,
    output logic            core_stall,
    output logic            wake_up,
    output logic            power_up_class,
    output logic            retained_valid,
    output logic            por_flag_n,
    output logic [8:0]      trip_level_10mv,
    output logic            brownout_reset_active,
    output logic            master_clear_pin_o,
    output logic            master_clear_pin_oe
);
    function automatic logic is_crystal(input logic [1:0] mode);
        return mode != OSC_RC;
    endfunction : is_crystal

    function automatic logic [8:0] trip_level(input logic [1:0] sel);
        case (sel)
            2'h3:    return TRIP_2V5;
            2'h2:    return TRIP_2V7;
            2'h1:    return TRIP_4V2;
            default: return TRIP_4V5;
        endcase
    endfunction : trip_level

    // synchronisers: bit 0 por, 1 brown-out, 2 clear, 3 rc clk, 4 osc pin
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // clear pin idles high; avoids a false request after reset
            sync1_q <= 5'h04;
            sync2_q <= 5'h04;
            sync3_q <= 5'h04;
        end else begin
            sync1_q <= {oscillator_input_pin, internal_rc_clock,
                        master_clear_pin, brownout_detect, por_pulse};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic por_rise;
    logic rc_edge;
    logic osc_edge;
    assign por_rise = sync2_q[0] & ~sync3_q[0];
    assign rc_edge  = sync2_q[3] & ~sync3_q[3];
    assign osc_edge = sync2_q[4] & ~sync3_q[4];

    filter_if clear_f ();
    filter_if brownout_f ();
    assign clear_f.raw    = ~sync2_q[2];
    assign brownout_f.raw = sync2_q[1];

    dwell_filter #(.LEN(CLEAR_FILTER_CYC)) u_clear_filter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .port    (clear_f)
    );

    dwell_filter #(.LEN(BROWNOUT_MIN_CYC)) u_brownout_filter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .port    (brownout_f)
    );

    logic clear_ok;
    logic brownout_active;
    assign clear_ok        = ~clear_f.active;
    assign brownout_active = brownout_f.active & brownout_enable_bit;

    seq_state_t  state_q;
    seq_state_t  state_d;
    logic [15:0] delay_cnt_q;
    logic [10:0] osc_cnt_q;
    logic        wake_q;
    logic        delay_done;
    logic        osc_done;
    logic        wake_evt;
    logic        watchdog_rst;

    assign delay_done = rc_edge && (delay_cnt_q == 16'(DELAY_CYCLES - 1));
    assign osc_done   = osc_edge && (osc_cnt_q == 11'(OSC_START_COUNT - 1));
    assign wake_evt   = watchdog_timeout && sleep_active && state_q == S_DONE;
    assign watchdog_rst = watchdog_timeout && !sleep_active
                          && state_q == S_DONE;

    always_comb begin
        state_d = state_q;
        if (por_rise) begin
            state_d = S_START;
        end else if (brownout_active) begin
            state_d = S_BROWNOUT;
        end else begin
            case (state_q)
                S_START: begin
                    if (power_up_delay_enable_bit == DELAY_ON) begin
                        state_d = S_DELAY;
                    end else if (is_crystal(osc_mode)) begin
                        state_d = S_OSC_START;
                    end else begin
                        state_d = S_DONE;
                    end
                end
                S_BROWNOUT: state_d = S_DELAY;
                S_DELAY: begin
                    if (delay_done) begin
                        state_d = is_crystal(osc_mode) ? S_OSC_START
                                                       : S_DONE;
                    end
                end
                S_OSC_START: begin
                    if (osc_done) begin
                        state_d = S_DONE;
                    end
                end
                S_DONE: begin
                    // watchdog and clear resets never restart the timers
                    if (wake_evt && is_crystal(osc_mode)) begin
                        state_d = S_OSC_START;
                    end
                end
                default: state_d = S_START;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_START;
        end else begin
            state_q <= state_d;
        end
    end

    // counters step on synchronised rc and osc edges, blind to master-clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_cnt_q <= 16'h0000;
        end else if (state_q != S_DELAY) begin
            delay_cnt_q <= 16'h0000;
        end else if (rc_edge) begin
            delay_cnt_q <= delay_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_q <= 11'h000;
        end else if (state_q != S_OSC_START) begin
            osc_cnt_q <= 11'h000;
        end else if (osc_edge) begin
            osc_cnt_q <= osc_cnt_q + 11'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
        end else if (state_d != S_OSC_START) begin
            wake_q <= 1'b0;
        end else if (wake_evt) begin
            wake_q <= 1'b1;
        end
    end

    // core outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reset <= 1'b1;
            core_stall <= 1'b0;
            wake_up    <= 1'b0;
        end else begin
            core_reset <= (state_q != S_DONE && !wake_q)
                          || !clear_ok
                          || watchdog_rst;
            core_stall <= wake_q;
            wake_up    <= wake_evt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_up_class <= 1'b1;
        end else if (por_rise || brownout_active) begin
            power_up_class <= 1'b1;
        end else if (watchdog_rst || !clear_ok) begin
            power_up_class <= 1'b0;
        end
    end

    // reset event beats the software write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            retained_valid <= 1'b0;
        end else if (por_rise || brownout_active) begin
            retained_valid <= 1'b0;
        end else if (retained_written) begin
            retained_valid <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_flag_n <= 1'b0;
        end else if (por_rise) begin
            por_flag_n <= 1'b0;
        end else if (por_flag_set) begin
            por_flag_n <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_level_10mv       <= TRIP_4V5;
            brownout_reset_active <= 1'b0;
        end else begin
            trip_level_10mv       <= trip_level(brownout_trip_select);
            brownout_reset_active <= brownout_active;
        end
    end

    // the pin is never driven; watchdog reset stays internal
    assign master_clear_pin_o  = 1'b0;
    assign master_clear_pin_oe = 1'b0;

    a_brownout_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        brownout_active |-> ##2 core_reset)
        else $error("brown-out did not hold reset");

    a_brownout_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_BROWNOUT && !brownout_active && !por_rise
        |=> state_q == S_DELAY)
        else $error("brown-out recovery skipped delay");

    a_delay_not_early: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_DELAY && !delay_done && !por_rise && !brownout_active
        |=> state_q == S_DELAY)
        else $error("power-up delay left early");

    a_delay_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_q == S_DELAY) |-> delay_cnt_q == 16'h0000)
        else $error("power-up delay not reinitialised");

    a_osc_not_early: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_OSC_START && !osc_done && !por_rise && !brownout_active
        |=> state_q == S_OSC_START)
        else $error("oscillator count left early");

    a_rc_no_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_START && power_up_delay_enable_bit != DELAY_ON
        && osc_mode == OSC_RC && !por_rise && !brownout_active
        |=> state_q == S_DONE)
        else $error("rc mode without delay still timed out");

    a_wake_no_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wake_evt && clear_ok && !por_rise && !brownout_active
        |=> !core_reset ##1 !core_reset)
        else $error("watchdog wake-up caused a reset");

    a_watchdog_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
        watchdog_rst |=> core_reset && !master_clear_pin_oe)
        else $error("watchdog reset drove the pin or missed reset");

    a_clear_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clear_ok |=> core_reset)
        else $error("master-clear low did not hold reset");

    a_clear_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_DONE && !wake_q && clear_ok && !watchdog_rst
        |=> !core_reset)
        else $error("late master-clear release delayed start");

    a_por_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        por_rise |=> !por_flag_n && power_up_class)
        else $error("power-on flag not cleared");

    c_brownout_delay: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_DELAY ##1 state_q == S_BROWNOUT);
    c_wake_osc: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wake_evt ##1 state_q == S_OSC_START);
    c_full_powerup: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == S_OSC_START ##1 state_q == S_DONE);
endmodule : reset_timeout_sequencer

// ---- pkg/filter_if.sv ----
// carrier between the sequencer and a dwell filter
// assumes both ends sit on sys_clk
`timescale 1ns/1ps
interface filter_if;
    logic raw;
    logic active;
    modport filt (input raw, output active);
    modport user (output raw, input active);
endinterface : filter_if

// ---- pkg/reset_seq_pkg.sv ----
// package of constants and types for the reset and time-out sequencer
// assumes sys_clk at 20 MHz and an on-chip rc clock of RC_CLOCK_HZ
//
// Function
// - power-on and brown-out are power-up resets; master-clear, watchdog are not
// - retained registers go unknown on power-up resets, kept on all others
// - watchdog time-out during sleep is a wake-up, never a reset
// - master-clear path filters out short pulses on the pin
// - watchdog reset never drives the master-clear pin low
// - supply-rise pulse produces power-on reset and starts the time-out sequence
// - power-up delay is nominal 72 ms, only after power-up resets
// - delay starts at power-on pulse, or at brown-out recovery
// - power-up delay runs on rc clock; reset held while it runs
// - delay enable bit governs power-on only; brown-out always uses delay
// - after delay, count 1024 oscillator pin cycles, reset held meanwhile
// - oscillator count only in crystal modes, after power-up reset or wake
// - two-bit field selects one of four brown-out trip levels
// - brown-out enable bit set enables brown-out reset, cleared disables
// - brown-out reset only when supply stays low past minimum duration
// - brown-out holds reset until supply recovers, then 72 ms delay
// - brown-out during delay restarts the delay from zero after recovery
// - delay first, then oscillator count; rc mode without delay has none
// - time-outs run regardless of master-clear; late release starts at once
// - delay enable bit is active low: 0 enables, 1 disables
// - trip select 11=2.5V, 10=2.7V, 01=4.2V, 00=4.5V to detector
// - power-on status flag cleared by power-on reset only
package reset_seq_pkg;

    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned RC_CLOCK_HZ    = 100000;
    localparam int unsigned DELAY_MS       = 72;
    localparam int unsigned DELAY_COUNT    =
        DELAY_MS * RC_CLOCK_HZ / 1000;
    localparam int unsigned OSC_START_COUNT = 1024;
    // minimum pulse widths; least times round up
    localparam int unsigned CLEAR_FILTER_NS = 200;
    localparam int unsigned CLEAR_FILTER_CYC =
        (CLEAR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BROWNOUT_MIN_NS = 100000;
    localparam int unsigned BROWNOUT_MIN_CYC =
        (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] OSC_LOW_POWER  = 2'h0;
    localparam logic [1:0] OSC_STANDARD   = 2'h1;
    localparam logic [1:0] OSC_HIGH_SPEED = 2'h2;
    localparam logic [1:0] OSC_RC         = 2'h3;

    // trip levels in 10 mV steps
    localparam logic [8:0] TRIP_2V5 = 9'h0FA;
    localparam logic [8:0] TRIP_2V7 = 9'h10E;
    localparam logic [8:0] TRIP_4V2 = 9'h1A4;
    localparam logic [8:0] TRIP_4V5 = 9'h1C2;

    localparam logic DELAY_ON = 1'b0;

    typedef enum logic [4:0] {
        S_START    = 5'h01,
        S_BROWNOUT = 5'h02,
        S_DELAY     = 5'h04,
        S_OSC_START = 5'h08,
        S_DONE     = 5'h10
    } seq_state_t;

endpackage : reset_seq_pkg

// ---- tb/reset_timeout_sequencer_test.sv ----
// self-checking bench for the reset and time-out sequencer
// assumes the design alone, inputs driven 5 ns after sys_clk rises
`timescale 1ns/1ps
module reset_timeout_sequencer_test
    import reset_seq_pkg::*;
;
    localparam int PW  = 600; // shortened delay keeps the run short
    localparam int RCP = 4;   // rc and osc periods in sys_clk cycles
    logic       sys_clk, rst_n, por_pulse, brownout_detect;
    logic       master_clear_pin, watchdog_timeout, sleep_active;
    logic       internal_rc_clock, oscillator_input_pin;
    logic [1:0] osc_mode, brownout_trip_select;
    logic       brownout_enable_bit, power_up_delay_enable_bit;
    logic       retained_written, por_flag_set;
    logic       core_reset, core_stall, wake_up, power_up_class;
    logic       retained_valid, por_flag_n, brownout_reset_active;
    logic       master_clear_pin_o, master_clear_pin_oe;
    logic [8:0] trip_level_10mv;
    int         num_errors, checked, hi_cnt, stall_cnt, wake_cnt, e, k;

    reset_timeout_sequencer #(.DELAY_CYCLES(PW)) dut (.*);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // rc and osc free-run, out of phase with sys_clk
    initial begin
        internal_rc_clock = 1'b0;
        #13;
        forever #100 internal_rc_clock = ~internal_rc_clock;
    end
    initial begin
        oscillator_input_pin = 1'b0;
        #37;
        forever #100 oscillator_input_pin = ~oscillator_input_pin;
    end
    always @(posedge sys_clk) begin
        if (core_reset === 1'b1) hi_cnt++;
        if (core_stall === 1'b1) stall_cnt++;
        if (wake_up === 1'b1) wake_cnt++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : step
    task automatic clr();
        hi_cnt = 0;
        stall_cnt = 0;
        wake_cnt = 0;
    endtask : clr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input int v, input int lo, input int hi);
        chk((v >= lo && v <= hi) ? lo : v, lo);
    endtask : chk_in
    task automatic conclude();
        $display("num_errors=%0d checked=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    task automatic wait_idle();
        int i;
        for (i = 0; i < 30000; i++) begin
            if (core_reset === 1'b0 && core_stall === 1'b0) break;
            step(1);
        end
        if (i == 30000) begin
            num_errors++;
            conclude();
        end
        step(2);
    endtask : wait_idle
    task automatic pulse_watchdog();
        watchdog_timeout = 1'b1;
        step(1);
        watchdog_timeout = 1'b0;
    endtask : pulse_watchdog
    function automatic int exp_cyc(input logic [1:0] m, input logic pe,
                                   input logic bo);
        exp_cyc = ((pe == DELAY_ON || bo) ? PW * RCP : 0)
                + ((m != OSC_RC) ? OSC_START_COUNT * RCP : 0);
    endfunction : exp_cyc
    function automatic logic [8:0] exp_trip(input logic [1:0] s);
        case (s)
            2'h3: exp_trip = TRIP_2V5;
            2'h2: exp_trip = TRIP_2V7;
            2'h1: exp_trip = TRIP_4V2;
            default: exp_trip = TRIP_4V5;
        endcase
    endfunction : exp_trip
    task automatic power_up(input logic [1:0] m, input logic pe);
        osc_mode = m;
        power_up_delay_enable_bit = pe;
        e = exp_cyc(m, pe, 1'b0);
        clr();
        por_pulse = 1'b1;
        step(4);
        por_pulse = 1'b0;
        step(2);
        wait_idle();
        chk_in(hi_cnt, (e == 0) ? 1 : e - 8, e + 40);
        chk(power_up_class, 1'b1);
        chk(por_flag_n, 1'b0);
        chk(retained_valid, 1'b0);
    endtask : power_up

    initial begin
        void'($urandom(32'hBC1F));
        {por_pulse, brownout_detect, watchdog_timeout, sleep_active} = 4'h0;
        {retained_written, por_flag_set, brownout_enable_bit} = 3'h0;
        master_clear_pin = 1'b1;
        osc_mode = OSC_STANDARD;
        power_up_delay_enable_bit = DELAY_ON;
        brownout_trip_select = 2'($urandom);
        num_errors = 0;
        checked = 0;
        clr();
        rst_n = 1'b0;
        step(5);
        chk(core_reset, 1'b1);
        chk(trip_level_10mv, {23'h0, TRIP_4V5});
        chk(master_clear_pin_oe, 1'b0);
        rst_n = 1'b1;
        wait_idle();
        for (int s = 0; s < 4; s++) begin
            brownout_trip_select = 2'(s);
            step(3);
            chk(trip_level_10mv, exp_trip(2'(s)));
        end
        // every mode with the delay bit both ways
        for (int j = 0; j < 8; j++) begin
            power_up(2'(j), j[2]);
        end
        por_flag_set = 1'b1;
        retained_written = 1'b1;
        step(1);
        por_flag_set = 1'b0;
        retained_written = 1'b0;
        for (int j = 0; j < 4; j++) begin
            clr();
            master_clear_pin = 1'b0;
            step($urandom_range(1, 3));
            master_clear_pin = 1'b1;
            step(8);
            chk(hi_cnt, 0);
        end
        master_clear_pin = 1'b0;
        step($urandom_range(10, 30));
        chk(core_reset, 1'b1);
        chk(power_up_class, 1'b0);
        clr();
        master_clear_pin = 1'b1;
        wait_idle();
        chk_in(hi_cnt, 0, 4);
        chk(retained_valid, 1'b1);
        chk(por_flag_n, 1'b1);
        clr();
        pulse_watchdog();
        step(4);
        chk_in(hi_cnt, 1, 2);
        chk(power_up_class, 1'b0);
        chk(master_clear_pin_oe, 1'b0);
        chk(retained_valid, 1'b1);
        // watchdog during sleep wakes, never resets
        sleep_active = 1'b1;
        for (int j = 0; j < 4; j++) begin
            osc_mode = 2'(j);
            e = exp_cyc(2'(j), 1'b1, 1'b0);
            clr();
            pulse_watchdog();
            step(3);
            wait_idle();
            chk(wake_cnt, 1);
            chk(hi_cnt, 0);
            chk_in(stall_cnt, (e == 0) ? 0 : e - 8, e + 40);
            chk(retained_valid, 1'b1);
        end
        sleep_active = 1'b0;
        clr();
        brownout_detect = 1'b1;
        step(2100);
        brownout_detect = 1'b0;
        step(4);
        chk(hi_cnt, 0);
        brownout_enable_bit = 1'b1;
        brownout_detect = 1'b1;
        step($urandom_range(500, 1900));
        brownout_detect = 1'b0;
        step(4);
        chk(hi_cnt, 0);
        osc_mode = OSC_RC;
        power_up_delay_enable_bit = ~DELAY_ON;
        brownout_detect = 1'b1;
        step(2100);
        chk(brownout_reset_active, 1'b1);
        chk(core_reset, 1'b1);
        brownout_detect = 1'b0;
        step(500);
        // second dip begins while the delay runs, qualifies after it ends and starts a new one
        brownout_detect = 1'b1;
        step(2100);
        chk(core_reset, 1'b1);
        brownout_detect = 1'b0;
        clr();
        wait_idle();
        e = exp_cyc(OSC_RC, ~DELAY_ON, 1'b1);
        chk_in(hi_cnt, e - 8, e + 40);
        chk(power_up_class, 1'b1);
        chk(por_flag_n, 1'b1);
        chk(retained_valid, 1'b0);
        brownout_enable_bit = 1'b0;
        osc_mode = OSC_STANDARD;
        power_up_delay_enable_bit = DELAY_ON;
        master_clear_pin = 1'b0;
        por_pulse = 1'b1;
        step(4);
        por_pulse = 1'b0;
        step(exp_cyc(OSC_STANDARD, DELAY_ON, 1'b0) + 200);
        chk(core_reset, 1'b1);
        clr();
        master_clear_pin = 1'b1;
        wait_idle();
        chk_in(hi_cnt, 0, 4);
        conclude();
    end
endmodule : reset_timeout_sequencer_test
